/* design/pss_defs.vh */
// pss_defs.vh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the power stage config bank
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

`define PSS_CMD_USER_FEATURE   8'hD1
`define PSS_CMD_CURRENT_SHARE  8'hD2

`define PSS_UFS_RESET          16'h2011
`define PSS_CSS_RESET          16'h0000
// bits 12,10,7,4,3 always written as zero (bit 4 is one after reset), standby keeps both bits
`define PSS_UFS_WMASK          16'hEB67
// share id limited to 5 bits, bit 1 reserved
`define PSS_CSS_WMASK          16'h1FFD

`define PSS_UFS_MIN_DUTY_HI    15
`define PSS_UFS_MIN_DUTY_LO    14
`define PSS_UFS_MIN_DUTY_EN    13
`define PSS_UFS_SYNC_TMO_EN    11
`define PSS_UFS_FF_BYPASS      9
`define PSS_UFS_FAULT_SPREAD   8
`define PSS_UFS_SYNC_USE_EXT   6
`define PSS_UFS_SYNC_OUT_EN    5
`define PSS_UFS_LS_ON_OFF      2
`define PSS_UFS_STBY_HI        1
`define PSS_UFS_STBY_LO        0

`define PSS_CSS_ID_HI          12
`define PSS_CSS_ID_LO          8
`define PSS_CSS_CNT_HI         7
`define PSS_CSS_CNT_LO         5
`define PSS_CSS_POS_HI         4
`define PSS_CSS_POS_LO         2
`define PSS_CSS_MEMBER         0

`define PSS_STBY_LOW_POWER     2'h0
`define PSS_STBY_MON_CONT      2'h1
`define PSS_STBY_RESERVED      2'h2
`define PSS_STBY_MON_PULSED    2'h3

`define PSS_CLK_HZ             20000000
`define PSS_SYNC_TMO_MS        500
`define PSS_SYNC_TMO_CYC       ((`PSS_CLK_HZ / 1000) * `PSS_SYNC_TMO_MS)
`define PSS_ACT_WIN_CYC        64

`endif

/* design/pss_config_bank.v */
// pss_config_bank.v: user feature and current share setup registers with the
// behaviour they steer (min duty clamp, switch clock pin, fault spreading,
// disabled-state drive and standby monitoring, share rail membership).
// assumes: a protocol engine on clk delivers the command code and data bytes;
// the switch clock pin arrives asynchronously and is synchronised here.
`timescale 1ns/1ps
`include "pss_defs.vh"

module pss_config_bank #(
    parameter SYNC_TMO_CYC = `PSS_SYNC_TMO_CYC,
    parameter ACT_WIN_CYC  = `PSS_ACT_WIN_CYC
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_code,
    input  wire        wr_valid,
    input  wire [7:0]  wr_byte,
    input  wire        rd_req,
    output wire        cmd_hit,
    output reg  [7:0]  rd_byte,
    output reg         rd_valid,
    input  wire        dev_enabled,
    input  wire        ramp_active,
    input  wire [7:0]  duty_req,
    output reg  [7:0]  duty_out,
    output reg         ff_correct_en,
    input  wire        seq_enabled,
    input  wire        ext_fault,
    input  wire        ext_fault_in_group,
    output reg         shutdown_now,
    output reg         seq_down_req,
    input  wire        freq_from_pin,
    input  wire        int_sw_clk,
    input  wire        sync_pin_in,
    output reg         sync_pin_out,
    output reg         sync_pin_oe_n,
    output reg         use_ext_clk,
    output reg         low_side_on,
    output reg         low_power_mode,
    output reg         monitor_cont,
    output reg         monitor_pulsed,
    output reg         telemetry_avail,
    input  wire [4:0]  bus_id,
    output reg         share_member,
    output reg  [2:0]  share_count_m1,
    output reg  [2:0]  share_position,
    output reg         share_id_mismatch
);

    localparam CW = 24;
    localparam [31:0]   TMO_LAST_W = SYNC_TMO_CYC - 1;
    localparam [31:0]   WIN_LAST_W = ACT_WIN_CYC - 1;
    // counts fit in CW bits, cut on purpose
    localparam [CW-1:0] TMO_LAST   = TMO_LAST_W[CW-1:0];
    localparam [CW-1:0] WIN_LAST   = WIN_LAST_W[CW-1:0];

    reg  [15:0]   user_feature_setup_ff;
    reg  [15:0]   current_share_setup_ff;
    reg  [7:0]    code_ff;
    reg  [1:0]    idx_ff;
    reg  [7:0]    low_ff;
    reg  [CW-1:0] tmo_cnt_ff;
    reg           sync_run_ff;
    reg           sync_m1_ff;
    reg           sync_m2_ff;
    reg           sync_m3_ff;
    reg           sync_lvl_ff;
    reg  [CW-1:0] act_cnt_ff;
    reg           pin_active_ff;

    reg  [15:0]   nxt_ufs;
    reg  [15:0]   nxt_css;
    reg  [15:0]   rd_word;
    reg  [8:0]    min_duty;

    wire hit_ufs = (code_ff == `PSS_CMD_USER_FEATURE);
    wire hit_css = (code_ff == `PSS_CMD_CURRENT_SHARE);
    wire [1:0] stby = user_feature_setup_ff[`PSS_UFS_STBY_HI:`PSS_UFS_STBY_LO];
    wire [1:0] n_dty = user_feature_setup_ff[`PSS_UFS_MIN_DUTY_HI:`PSS_UFS_MIN_DUTY_LO];

    assign cmd_hit = hit_ufs | hit_css;

    // word assembly, low byte first, commit on second byte
    always @* begin
        nxt_ufs = user_feature_setup_ff;
        nxt_css = current_share_setup_ff;
        if (wr_valid && !cmd_valid && idx_ff == 2'h1) begin
            if (hit_ufs) begin
                nxt_ufs = {wr_byte, low_ff} & `PSS_UFS_WMASK;
            end
            if (hit_css) begin
                nxt_css = {wr_byte, low_ff} & `PSS_CSS_WMASK;
            end
        end
    end

    always @* begin
        rd_word = 16'h0000;
        if (hit_ufs) begin
            rd_word = user_feature_setup_ff;
        end else if (hit_css) begin
            rd_word = current_share_setup_ff;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            user_feature_setup_ff  <= `PSS_UFS_RESET;
            current_share_setup_ff <= `PSS_CSS_RESET;
            code_ff  <= 8'h00;
            idx_ff   <= 2'h0;
            low_ff   <= 8'h00;
            rd_byte  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            user_feature_setup_ff  <= nxt_ufs;
            current_share_setup_ff <= nxt_css;
            rd_valid <= 1'b0;
            if (cmd_valid) begin
                code_ff <= cmd_code;
                idx_ff  <= 2'h0;
            end else if (wr_valid) begin
                if (idx_ff == 2'h0) begin
                    low_ff <= wr_byte;
                end
                if (idx_ff != 2'h2) begin
                    idx_ff <= idx_ff + 2'h1;
                end
            end else if (rd_req) begin
                rd_valid <= 1'b1;
                // low byte then high byte, zero beyond the word
                case (idx_ff)
                    2'h0:    rd_byte <= rd_word[7:0];
                    2'h1:    rd_byte <= rd_word[15:8];
                    default: rd_byte <= 8'h00;
                endcase
                if (idx_ff != 2'h2) begin
                    idx_ff <= idx_ff + 2'h1;
                end
            end
        end
    end

    // switch clock pin: three stage synchroniser, change on 2nd/3rd agree
    always @(posedge clk) begin
        if (srst) begin
            sync_m1_ff  <= 1'b0;
            sync_m2_ff  <= 1'b0;
            sync_m3_ff  <= 1'b0;
            sync_lvl_ff <= 1'b0;
        end else begin
            sync_m1_ff <= sync_pin_in;
            sync_m2_ff <= sync_m1_ff;
            sync_m3_ff <= sync_m2_ff;
            if (sync_m2_ff == sync_m3_ff) begin
                sync_lvl_ff <= sync_m3_ff;
            end
        end
    end

    // pin activity: an edge seen within the last window
    always @(posedge clk) begin
        if (srst) begin
            act_cnt_ff    <= {CW{1'b0}};
            pin_active_ff <= 1'b0;
        end else if (sync_m2_ff == sync_m3_ff && sync_m3_ff != sync_lvl_ff) begin
            act_cnt_ff    <= {CW{1'b0}};
            pin_active_ff <= 1'b1;
        end else if (act_cnt_ff == WIN_LAST) begin
            pin_active_ff <= 1'b0;
        end else begin
            act_cnt_ff <= act_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // switch clock output timeout after disable
    always @(posedge clk) begin
        if (srst) begin
            tmo_cnt_ff  <= {CW{1'b0}};
            sync_run_ff <= 1'b1;
        end else if (dev_enabled || !user_feature_setup_ff[`PSS_UFS_SYNC_TMO_EN]) begin
            tmo_cnt_ff  <= {CW{1'b0}};
            sync_run_ff <= 1'b1;
        end else if (tmo_cnt_ff == TMO_LAST) begin
            sync_run_ff <= 1'b0;
        end else begin
            tmo_cnt_ff <= tmo_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        min_duty = {7'h00, n_dty} + 9'h001;
    end

    // steered behaviour, registered
    always @(posedge clk) begin
        if (srst) begin
            duty_out          <= 8'h00;
            ff_correct_en     <= 1'b0;
            shutdown_now      <= 1'b0;
            seq_down_req      <= 1'b0;
            use_ext_clk       <= 1'b0;
            sync_pin_out      <= 1'b0;
            sync_pin_oe_n     <= 1'b1;
            low_side_on       <= 1'b0;
            low_power_mode    <= 1'b0;
            monitor_cont      <= 1'b0;
            monitor_pulsed    <= 1'b0;
            telemetry_avail   <= 1'b0;
            share_member      <= 1'b0;
            share_count_m1    <= 3'h0;
            share_position    <= 3'h0;
            share_id_mismatch <= 1'b0;
        end else begin
            if (ramp_active && user_feature_setup_ff[`PSS_UFS_MIN_DUTY_EN]
                && {1'b0, duty_req} < min_duty) begin
                duty_out <= min_duty[7:0];
            end else begin
                duty_out <= duty_req;
            end
            ff_correct_en <= !user_feature_setup_ff[`PSS_UFS_FF_BYPASS];
            shutdown_now <= ext_fault && ext_fault_in_group
                            && user_feature_setup_ff[`PSS_UFS_FAULT_SPREAD];
            seq_down_req <= ext_fault && seq_enabled
                            && !user_feature_setup_ff[`PSS_UFS_FAULT_SPREAD];
            use_ext_clk <= user_feature_setup_ff[`PSS_UFS_SYNC_USE_EXT]
                           || (freq_from_pin && pin_active_ff);
            sync_pin_out <= int_sw_clk;
            sync_pin_oe_n <= !(user_feature_setup_ff[`PSS_UFS_SYNC_OUT_EN]
                               && !use_ext_clk && sync_run_ff);
            low_side_on <= !dev_enabled
                           && user_feature_setup_ff[`PSS_UFS_LS_ON_OFF];
            low_power_mode  <= 1'b0;
            monitor_cont    <= 1'b0;
            monitor_pulsed  <= 1'b0;
            telemetry_avail <= dev_enabled;
            if (!dev_enabled) begin
                case (stby)
                    `PSS_STBY_MON_CONT: begin
                        monitor_cont    <= 1'b1;
                        telemetry_avail <= 1'b1;
                    end
                    `PSS_STBY_MON_PULSED: begin
                        monitor_pulsed  <= 1'b1;
                        telemetry_avail <= 1'b1;
                    end
                    default: begin
                        low_power_mode  <= 1'b1;
                        telemetry_avail <= 1'b0;
                    end
                endcase
            end
            share_member   <= current_share_setup_ff[`PSS_CSS_MEMBER];
            share_count_m1 <= current_share_setup_ff[`PSS_CSS_CNT_HI:`PSS_CSS_CNT_LO];
            share_position <= current_share_setup_ff[`PSS_CSS_POS_HI:`PSS_CSS_POS_LO];
            share_id_mismatch <= current_share_setup_ff[`PSS_CSS_MEMBER] &&
                (current_share_setup_ff[`PSS_CSS_ID_HI:`PSS_CSS_ID_LO] != bus_id);
        end
    end

endmodule // pss_config_bank

/* sim/pss_config_bank_properties.sv */
// pss_config_bank_properties.sv: port-level checks for the config bank
// assumes: bound into pss_config_bank, one clk domain, srst synchronous
`timescale 1ns/1ps
module pss_checker (
    input wire       clk,
    input wire       srst,
    input wire       cmd_valid,
    input wire       wr_valid,
    input wire       rd_req,
    input wire       rd_valid,
    input wire       ramp_active,
    input wire [7:0] duty_req,
    input wire [7:0] duty_out,
    input wire       dev_enabled,
    input wire       seq_enabled,
    input wire       ext_fault,
    input wire       ext_fault_in_group,
    input wire       shutdown_now,
    input wire       seq_down_req,
    input wire       low_side_on,
    input wire       telemetry_avail,
    input wire       share_member,
    input wire       share_id_mismatch
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);
    a_read_answered: assert property (rd_req && !cmd_valid && !wr_valid |=> rd_valid)
        else $error("read not answered");
    a_read_cause: assert property (rd_valid |-> $past(rd_req))
        else $error("read data without request");
    a_group_shutdown: assert property (shutdown_now |-> $past(ext_fault && ext_fault_in_group))
        else $error("shutdown without group fault");
    a_seq_down_cause: assert property (seq_down_req |-> $past(ext_fault && seq_enabled))
        else $error("sequence down without cause");
    a_fault_modes_apart: assert property (!(shutdown_now && seq_down_req))
        else $error("both fault reactions at once");
    a_duty_pass: assert property (!$past(srst) && !$past(ramp_active) |->
        duty_out == $past(duty_req)) else $error("duty altered outside ramp");
    a_duty_floor: assert property (!$past(srst) && $past(ramp_active) |-> duty_out >= $past(duty_req)
        && (duty_out == $past(duty_req) || duty_out <= 8'h04)) else $error("duty floor wrong");
    a_low_side_idle: assert property (low_side_on |-> !$past(dev_enabled))
        else $error("low side on while enabled");
    a_telemetry_on: assert property (!$past(srst) && $past(dev_enabled) |-> telemetry_avail)
        else $error("telemetry missing while enabled");
    a_id_member: assert property (share_id_mismatch |-> share_member)
        else $error("id mismatch outside rail");
    c_shutdown: cover property (shutdown_now);
    c_seq_down: cover property (seq_down_req);
    c_word_read: cover property (rd_valid ##1 rd_valid);
endmodule // pss_checker

bind pss_config_bank pss_checker u_chk (.clk, .srst, .cmd_valid, .wr_valid, .rd_req, .rd_valid,
    .ramp_active, .duty_req, .duty_out, .dev_enabled, .seq_enabled, .ext_fault,
    .ext_fault_in_group, .shutdown_now, .seq_down_req, .low_side_on, .telemetry_avail,
    .share_member, .share_id_mismatch);

/* sim/pss_host_model.sv */
// pss_host_model.sv: bus host issuing command codes and word transfers
// assumes: byte command side of pss_config_bank, driven 1 ns after clk
`timescale 1ns/1ps
module pss_host_model (
    input  wire        clk,
    input  wire        rd_valid,
    input  wire  [7:0] rd_byte,
    output logic       cmd_valid,
    output logic [7:0] cmd_code,
    output logic       wr_valid,
    output logic [7:0] wr_byte,
    output logic       rd_req
);
    initial begin
        cmd_valid = 1'h0;
        cmd_code  = 8'h00;
        wr_valid  = 1'h0;
        wr_byte   = 8'h00;
        rd_req    = 1'h0;
    end
    task automatic send_cmd(input logic [7:0] code);
        @(posedge clk) #1;
        cmd_valid = 1'h1;
        cmd_code  = code;
        @(posedge clk) #1;
        cmd_valid = 1'h0;
        cmd_code  = ~code;
    endtask
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        send_cmd(code);
        wr_valid = 1'h1;
        wr_byte  = data[7:0];
        @(posedge clk) #1;
        wr_byte  = data[15:8];
        @(posedge clk) #1;
        wr_valid = 1'h0;
        wr_byte  = ~data[15:8];
    endtask
    task automatic read_word(input logic [7:0] code, output logic [15:0] data, output logic ok);
        send_cmd(code);
        rd_req = 1'h1;
        @(posedge clk) #1;
        ok         = rd_valid;
        data[7:0]  = rd_byte;
        @(posedge clk) #1;
        ok         = ok & rd_valid;
        data[15:8] = rd_byte;
        rd_req     = 1'h0;
    endtask
endmodule // pss_host_model

/* sim/testbench.sv */
// testbench.sv: directed register and behaviour sequences for pss_config_bank
// assumes: pss_host_model drives the command side, bench drives the rest
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic        dev_enabled = 1'h0, ramp_active = 1'h0, seq_enabled = 1'h0;
    logic        ext_fault = 1'h0, ext_fault_in_group = 1'h0, int_sw_clk = 1'h0;
    logic        freq_from_pin = 1'h0, sync_pin_in = 1'h0;
    logic [7:0]  duty_req = 8'h00;
    logic [4:0]  bus_id = 5'h1F;
    logic [15:0] rdata;
    logic        ok;
    int          fail_count = 0, samples_checked = 0, n;
    wire         cmd_valid, wr_valid, rd_req, rd_valid, ff_correct_en, shutdown_now;
    wire         seq_down_req, sync_pin_out, sync_pin_oe_n, use_ext_clk, low_side_on;
    wire         low_power_mode, monitor_cont, monitor_pulsed, telemetry_avail;
    wire         share_member, share_id_mismatch, cmd_hit;
    wire [7:0]   cmd_code, wr_byte, rd_byte, duty_out;
    wire [2:0]   share_count_m1, share_position;
    logic [2:0]  mode_tab [4] = '{3'h4, 3'h2, 3'h4, 3'h1};
    always #25 clk = ~clk;
    always @(posedge clk) int_sw_clk <= ~int_sw_clk;
    pss_config_bank #(.SYNC_TMO_CYC(20)) i_dut (.clk, .srst, .cmd_valid, .cmd_code, .wr_valid,
        .wr_byte, .rd_req, .cmd_hit, .rd_byte, .rd_valid, .dev_enabled, .ramp_active,
        .duty_req, .duty_out, .ff_correct_en, .seq_enabled, .ext_fault, .ext_fault_in_group,
        .shutdown_now, .seq_down_req, .freq_from_pin, .int_sw_clk, .sync_pin_in,
        .sync_pin_out, .sync_pin_oe_n, .use_ext_clk, .low_side_on, .low_power_mode,
        .monitor_cont, .monitor_pulsed, .telemetry_avail, .bus_id, .share_member,
        .share_count_m1, .share_position, .share_id_mismatch);
    pss_host_model i_host (.clk, .rd_valid, .rd_byte, .cmd_valid, .cmd_code, .wr_valid,
        .wr_byte, .rd_req);
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        i_host.read_word(code, rdata, ok);
        check("read word", rdata, exp);
        check("read valid", ok, 1'h1);
    endtask
    // derived outputs settle one edge after the register, sync_pin_oe_n up to two
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        i_host.write_word(code, data);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic fault(input logic grp, seq, input logic [1:0] exp);
        @(posedge clk) #1;
        ext_fault_in_group = grp;
        seq_enabled = seq;
        ext_fault = 1'h1;
        @(posedge clk) #1;
        ext_fault = 1'h0;
        check("fault outs", {shutdown_now, seq_down_req}, exp);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 srst = 1'h0;
        rd(8'hD1, 16'h2011);
        check("cmd hit", cmd_hit, 1'h1);
        rd(8'hD2, 16'h0000);
        rd(8'hD3, 16'h0000);
        check("cmd miss", cmd_hit, 1'h0);
        check("reset telemetry", telemetry_avail, 1'h1);
        check("reset outs", {ff_correct_en, monitor_cont, low_side_on, share_member}, 4'hC);
        ramp_active = 1'h1;
        wr(8'hD1, 16'hFFFF);
        rd(8'hD1, 16'hEB67);
        check("duty floor", duty_out, 8'h04);
        check("ff low side clk", {ff_correct_en, low_side_on, use_ext_clk}, 3'h3);
        check("pulsed", {low_power_mode, monitor_cont, monitor_pulsed}, 3'h1);
        check("pulsed telemetry", telemetry_avail, 1'h1);
        for (n = 0; n < 4; n++) begin
            wr(8'hD1, 16'h2000 | n[15:0]);
            check("standby", {low_power_mode, monitor_cont, monitor_pulsed}, mode_tab[n]);
            check("duty min", duty_out, 8'h01);
            check("telemetry", telemetry_avail, !mode_tab[n][2]);
        end
        wr(8'hD1, 16'h0100);
        fault(1'h1, 1'h1, 2'h2);
        fault(1'h0, 1'h0, 2'h0);
        wr(8'hD1, 16'h0000);
        check("no floor", duty_out, 8'h00);
        fault(1'h1, 1'h1, 2'h1);
        fault(1'h1, 1'h0, 2'h0);
        check("pin input only", sync_pin_oe_n, 1'h1);
        dev_enabled = 1'h1;
        wr(8'hD1, 16'h0820);
        check("pin drive", {sync_pin_oe_n, sync_pin_out}, {1'h0, ~int_sw_clk});
        dev_enabled = 1'h0;
        for (n = 0; n < 40 && sync_pin_oe_n === 1'h0; n++)
            @(posedge clk) #1;
        check("sync stop", n >= 18 && n <= 24, 1'h1);
        dev_enabled = 1'h1;
        wr(8'hD1, 16'h0020);
        dev_enabled = 1'h0;
        repeat (40) @(posedge clk);
        #1 check("sync kept", sync_pin_oe_n, 1'h0);
        // auto mode: pin edge selects external clock, quiet pin falls back
        freq_from_pin = 1'h1;
        sync_pin_in = 1'h1;
        repeat (8) @(posedge clk);
        #1 check("ext clk auto", {use_ext_clk, sync_pin_oe_n}, 2'h3);
        repeat (80) @(posedge clk);
        #1 check("int clk auto", {use_ext_clk, sync_pin_oe_n}, 2'h0);
        wr(8'hD2, 16'hFF57);
        rd(8'hD2, 16'h1F55);
        check("share", {share_member, share_count_m1, share_position, share_id_mismatch}, 8'hAA);
        bus_id = 5'h03;
        repeat (2) @(posedge clk);
        #1 check("id differs", share_id_mismatch, 1'h1);
        complete_run();
    end
endmodule // testbench
